/* File: hw/dbg_pkg.sv */
// dbg_pkg: register map, reset values and power modes of the dual gpio.
// assumes an apb master with 32-bit data and a word per register.
package dbg_pkg;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_P4_DATA = 16'hFFD7;
  localparam logic [15:0] IDX_P5_DATA = 16'hFFD8;
  localparam logic [15:0] IDX_P4_DIR = 16'hFFE7;
  localparam logic [15:0] IDX_P5_DIR = 16'hFFE8;
  localparam logic [15:0] IDX_P5_PU = 16'hFFEF;
  localparam logic [15:0] IDX_P3_PU = 16'hFFF0;
  // reset values and fixed read values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PU = 8'h00;
  localparam logic [7:0] DIR_READ = 8'hFF;
  localparam logic [7:0] ALL_HIZ = 8'hFF;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
  // chip operating modes seen by the pins
  typedef enum logic [2:0] {
    PM_ACTIVE,
    PM_SUBACTIVE,
    PM_SLEEP,
    PM_SUBSLEEP,
    PM_WATCH,
    PM_STANDBY
  } dbg_mode_e;
  // pin drives follow the registers only while the core runs; pull-ups also follow in standby
  function automatic logic is_running(input dbg_mode_e m);
    return (m == PM_ACTIVE) || (m == PM_SUBACTIVE);
  endfunction
endpackage

/* File: hw/dbg_pin_if.sv */
// dbg_pin_if: register values into one pin stage and its pin drives back.
// assumes both ends sit in the pclk domain.
`timescale 1ns/1ps
interface dbg_pin_if;
  logic [7:0] dir;
  logic [7:0] data;
  logic [7:0] pu_ctl;
  dbg_pkg::dbg_mode_e mode;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] pu_on;
  modport ctl (output dir, data, pu_ctl, mode,
    input pin_out, pin_oe_n, pu_on);
  modport stage (input dir, data, pu_ctl, mode,
    output pin_out, pin_oe_n, pu_on);
endinterface

/* File: hw/dbg_port_stage.sv */
// dbg_port_stage: registered pin drive of one 8-bit port by power mode.
// assumes mode is synchronous to pclk.
`timescale 1ns/1ps
module dbg_port_stage #(
  parameter bit HAS_PU = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  dbg_pin_if.stage pif
);
  logic [7:0] out_r, out_nxt;
  logic [7:0] oe_n_r, oe_n_nxt;
  logic [7:0] pu_r, pu_nxt;
  logic [7:0] pu_want;

  // pull-up only on input pins whose control bit is set
  assign pu_want = {8{HAS_PU}} & pif.pu_ctl & ~pif.dir; // R1 R16

  // next pin state; sleep-like modes simply keep the last drive
  always_comb begin
    out_nxt = out_r;
    oe_n_nxt = oe_n_r;
    pu_nxt = pu_r;
    case (pif.mode)
      dbg_pkg::PM_ACTIVE, dbg_pkg::PM_SUBACTIVE: begin
        out_nxt = pif.data; // R3 R10
        oe_n_nxt = ~pif.dir; // R3 R10
        pu_nxt = pu_want;
      end
      dbg_pkg::PM_STANDBY: begin
        oe_n_nxt = dbg_pkg::ALL_HIZ; // R9
        pu_nxt = pu_want; // pulled pins read high in standby
      end
      dbg_pkg::PM_SLEEP, dbg_pkg::PM_SUBSLEEP,
      dbg_pkg::PM_WATCH: begin
        out_nxt = out_r; // R9
      end
      default: begin
        oe_n_nxt = dbg_pkg::ALL_HIZ;
        pu_nxt = dbg_pkg::RST_PU;
      end
    endcase
  end

  // reset floats every pin and drops every pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= dbg_pkg::RST_DATA;
      oe_n_r <= dbg_pkg::ALL_HIZ; // R9
      pu_r <= dbg_pkg::RST_PU; // R2
    end else begin
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
      pu_r <= pu_nxt;
    end
  end

  assign pif.pin_out = out_r;
  assign pif.pin_oe_n = oe_n_r;
  assign pif.pu_on = pu_r;
endmodule

/* File: hw/dbg_gpio.sv */
// dbg_gpio: ports four and five, pull-ups on port five only, plus port three pull-ups.
// assumes an apb master on pclk and pins synchronous to pclk.
`timescale 1ns/1ps
// Behaviour
// [R1] port3 pull-up on only for input pin with control bit set
// [R2] all port3 pull-ups off after reset
// [R3] port4 direction 1 drives latched data, 0 makes input
// [R4] port4 data read gives latched bit for output pins
// [R5] port4 data read gives pin level for input pins
// [R6] port4 data resets to zero
// [R7] port4 direction resets to zero, all inputs
// [R8] port4 direction is write-only, reads all ones
// [R9] pins float in reset and standby, hold in sleep modes
// [R10] port5 direction 1 drives latched data, 0 makes input
// [R11] port5 data read gives latched bit for output pins
// [R12] port5 data read gives pin level for input pins
// [R13] port5 data resets to zero
// [R14] port5 direction resets to zero, all inputs
// [R15] port5 direction is write-only, reads all ones
// [R16] port5 pull-up on for input pin with control bit set
// [R17] port5 pull-up control read-write, resets to zero
// [R18] byte access per register, writes land on next edge
module dbg_gpio #(
  parameter int PADDR_W = dbg_pkg::ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dbg_pkg::dbg_mode_e pwr_mode,
  input wire logic [7:0] port3_direction,
  output logic [7:0] port3_pu_on,
  input wire logic [7:0] p4_in,
  output logic [7:0] p4_out,
  output logic [7:0] p4_oe_n,
  input wire logic [7:0] p5_in,
  output logic [7:0] p5_out,
  output logic [7:0] p5_oe_n,
  output logic [7:0] p5_pu_on
);

  // the map needs eighteen address bits
  if (PADDR_W < dbg_pkg::ADDR_W) begin : g_addr_chk
    $error("dbg_gpio: PADDR_W below 18 cannot reach the map");
  end

  // byte address of a register index, compared on full bus width
  function automatic logic reg_hit(input logic [PADDR_W-1:0] a,
                                   input logic [15:0] idx);
    logic [PADDR_W-1:0] base;
    base = PADDR_W'({idx, 2'b00});
    return a == base;
  endfunction

  // read value of a port: latch for outputs, pin for inputs
  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] dat,
                                           input logic [7:0] pin);
    return (dir & dat) | (~dir & pin);
  endfunction

  logic [7:0] p4_data_r, p4_data_nxt;
  logic [7:0] p4_dir_r, p4_dir_nxt;
  logic [7:0] p5_data_r, p5_data_nxt;
  logic [7:0] p5_dir_r, p5_dir_nxt;
  logic [7:0] p5_pu_r, p5_pu_nxt;
  logic [7:0] p3_pu_r, p3_pu_nxt;
  logic [7:0] p3_on_r, p3_on_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic setup, wr_en, mapped;
  logic hit_p4d, hit_p4c, hit_p5d, hit_p5c, hit_p5u, hit_p3u;

  // address decode, reused by read and write paths
  assign hit_p4d = reg_hit(paddr, dbg_pkg::IDX_P4_DATA);
  assign hit_p4c = reg_hit(paddr, dbg_pkg::IDX_P4_DIR);
  assign hit_p5d = reg_hit(paddr, dbg_pkg::IDX_P5_DATA);
  assign hit_p5c = reg_hit(paddr, dbg_pkg::IDX_P5_DIR);
  assign hit_p5u = reg_hit(paddr, dbg_pkg::IDX_P5_PU);
  assign hit_p3u = reg_hit(paddr, dbg_pkg::IDX_P3_PU);
  assign mapped = hit_p4d | hit_p4c | hit_p5d | hit_p5c | hit_p5u |
                  hit_p3u;

  // answer is prepared in setup so pready can come from a flop
  assign setup = psel & ~penable;
  // writes land at the access edge; lane 0 carries the byte
  assign wr_en = psel & penable & pready_r & pwrite & pstrb[0] &
                 mapped; // R18

  // bus answer: zero wait states, error on unmapped addresses
  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt = dbg_pkg::RD_ZERO;
    if (setup && !pwrite) begin
      case (1'b1)
        hit_p4d: prdata_nxt[7:0] = port_read(p4_dir_r, p4_data_r,
                                             p4_in); // R4 R5
        hit_p5d: prdata_nxt[7:0] = port_read(p5_dir_r, p5_data_r,
                                             p5_in); // R11 R12
        hit_p4c: prdata_nxt[7:0] = dbg_pkg::DIR_READ; // R8
        hit_p5c: prdata_nxt[7:0] = dbg_pkg::DIR_READ; // R15
        hit_p5u: prdata_nxt[7:0] = p5_pu_r; // R17
        hit_p3u: prdata_nxt[7:0] = p3_pu_r;
        default: prdata_nxt = dbg_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= dbg_pkg::RD_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // register writes; one byte lane, upper data bits ignored
  always_comb begin
    p4_data_nxt = p4_data_r;
    p4_dir_nxt = p4_dir_r;
    p5_data_nxt = p5_data_r;
    p5_dir_nxt = p5_dir_r;
    p5_pu_nxt = p5_pu_r;
    p3_pu_nxt = p3_pu_r;
    if (wr_en) begin
      if (hit_p4d) p4_data_nxt = pwdata[7:0]; // R18
      if (hit_p4c) p4_dir_nxt = pwdata[7:0];
      if (hit_p5d) p5_data_nxt = pwdata[7:0];
      if (hit_p5c) p5_dir_nxt = pwdata[7:0];
      if (hit_p5u) p5_pu_nxt = pwdata[7:0]; // R17
      if (hit_p3u) p3_pu_nxt = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p4_data_r <= dbg_pkg::RST_DATA; // R6
      p4_dir_r <= dbg_pkg::RST_DIR; // R7
      p5_data_r <= dbg_pkg::RST_DATA; // R13
      p5_dir_r <= dbg_pkg::RST_DIR; // R14
      p5_pu_r <= dbg_pkg::RST_PU; // R17
      p3_pu_r <= dbg_pkg::RST_PU; // R2
    end else begin
      p4_data_r <= p4_data_nxt;
      p4_dir_r <= p4_dir_nxt;
      p5_data_r <= p5_data_nxt;
      p5_dir_r <= p5_dir_nxt;
      p5_pu_r <= p5_pu_nxt;
      p3_pu_r <= p3_pu_nxt;
    end
  end

  // port3 pull-ups; its direction comes from the port3 block.
  // they hold in sleep modes like the pins they serve
  always_comb begin
    p3_on_nxt = p3_on_r;
    if (pwr_mode == dbg_pkg::PM_ACTIVE ||
        pwr_mode == dbg_pkg::PM_SUBACTIVE ||
        pwr_mode == dbg_pkg::PM_STANDBY) begin
      p3_on_nxt = p3_pu_r & ~port3_direction; // R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p3_on_r <= dbg_pkg::RST_PU; // R2
    end else begin
      p3_on_r <= p3_on_nxt;
    end
  end

  // pin stages; port4 has no pull-ups
  dbg_pin_if p4_if ();
  dbg_pin_if p5_if ();

  assign p4_if.dir = p4_dir_r;
  assign p4_if.data = p4_data_r;
  assign p4_if.pu_ctl = dbg_pkg::RST_PU;
  assign p4_if.mode = pwr_mode;
  assign p5_if.dir = p5_dir_r;
  assign p5_if.data = p5_data_r;
  assign p5_if.pu_ctl = p5_pu_r;
  assign p5_if.mode = pwr_mode;

  dbg_port_stage #(.HAS_PU(1'b0)) u_p4 (
    .pclk(pclk),
    .presetn(presetn),
    .pif(p4_if.stage)
  );

  dbg_port_stage #(.HAS_PU(1'b1)) u_p5 (
    .pclk(pclk),
    .presetn(presetn),
    .pif(p5_if.stage)
  );

  // every output below is a flop in this module or a stage
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign port3_pu_on = p3_on_r;
  assign p4_out = p4_if.pin_out;
  assign p4_oe_n = p4_if.pin_oe_n;
  assign p5_out = p5_if.pin_out;
  assign p5_oe_n = p5_if.pin_oe_n;
  assign p5_pu_on = p5_if.pu_on;

  // checks: helper terms for a read in setup and for the running modes
  logic rd4d, rd5d, run;
  assign rd4d = setup & ~pwrite & hit_p4d;
  assign rd5d = setup & ~pwrite & hit_p5d;
  assign run = dbg_pkg::is_running(pwr_mode);

  property p_p3_pu;
    @(posedge pclk) disable iff (!presetn)
      run |=> port3_pu_on == ($past(p3_pu_r) & ~$past(port3_direction));
  endproperty
  a_p3_pu: assert property (p_p3_pu) // R1
    else $error("port3 pull-up does not follow control and direction");

  property p_pu_reset;
    @(posedge pclk) !presetn |-> port3_pu_on == 8'h00 &&
      p5_pu_on == 8'h00 && p3_pu_r == 8'h00;
  endproperty
  a_pu_reset: assert property (p_pu_reset) // R2
    else $error("pull-up on during reset");

  property p_p4_drive;
    @(posedge pclk) disable iff (!presetn)
      run |=> p4_oe_n == ~$past(p4_dir_r) && p4_out == $past(p4_data_r);
  endproperty
  a_p4_drive: assert property (p_p4_drive) // R3
    else $error("port4 pin drive does not match direction and data");

  property p_p4_rd_latch;
    @(posedge pclk) disable iff (!presetn)
      rd4d |=> pready && ((prdata[7:0] ^ $past(p4_data_r)) &
        $past(p4_dir_r)) == 8'h00;
  endproperty
  a_p4_rd_latch: assert property (p_p4_rd_latch) // R4
    else $error("port4 read misses latched data on output bits");

  property p_p4_rd_pin;
    @(posedge pclk) disable iff (!presetn)
      rd4d |=> ((prdata[7:0] ^ $past(p4_in)) & ~$past(p4_dir_r)) == 8'h00;
  endproperty
  a_p4_rd_pin: assert property (p_p4_rd_pin) // R5
    else $error("port4 read misses pin level on input bits");

  property p_rst_regs;
    @(posedge pclk) !presetn |-> p4_data_r == 8'h00 &&
      p5_data_r == 8'h00;
  endproperty
  a_rst_regs: assert property (p_rst_regs) // R6
    else $error("data register not cleared by reset");

  property p_rst_dir;
    @(posedge pclk) !presetn |-> p4_dir_r == 8'h00 &&
      p5_dir_r == 8'h00 && p4_oe_n == 8'hFF && p5_oe_n == 8'hFF;
  endproperty
  a_rst_dir: assert property (p_rst_dir) // R7
    else $error("direction not cleared or pins driven in reset");

  property p_p4_dir_rd;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_p4c |=> prdata == 32'h000000FF;
  endproperty
  a_p4_dir_rd: assert property (p_p4_dir_rd) // R8
    else $error("port4 direction read is not all ones");

  property p_standby;
    @(posedge pclk) disable iff (!presetn)
      pwr_mode == dbg_pkg::PM_STANDBY |=> p4_oe_n == 8'hFF &&
        p5_oe_n == 8'hFF;
  endproperty
  a_standby: assert property (p_standby) // R9
    else $error("pins driven in standby");

  property p_sleep_hold;
    @(posedge pclk) disable iff (!presetn)
      pwr_mode == dbg_pkg::PM_SLEEP ##1 pwr_mode == dbg_pkg::PM_SLEEP
        |-> $stable(p4_out) && $stable(p4_oe_n) && $stable(p5_out) &&
        $stable(p5_oe_n);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) // R9
    else $error("pins changed during sleep");

  property p_p5_drive;
    @(posedge pclk) disable iff (!presetn)
      run |=> p5_oe_n == ~$past(p5_dir_r) && p5_out == $past(p5_data_r);
  endproperty
  a_p5_drive: assert property (p_p5_drive) // R10
    else $error("port5 pin drive does not match direction and data");

  property p_p5_rd;
    @(posedge pclk) disable iff (!presetn)
      rd5d |=> prdata[7:0] == (($past(p5_dir_r) & $past(p5_data_r)) |
        (~$past(p5_dir_r) & $past(p5_in)));
  endproperty
  a_p5_rd: assert property (p_p5_rd) // R11 R12
    else $error("port5 read value wrong");

  property p_p5_dir_rd;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_p5c |=> prdata == 32'h000000FF;
  endproperty
  a_p5_dir_rd: assert property (p_p5_dir_rd) // R15
    else $error("port5 direction read is not all ones");

  property p_p5_pu;
    @(posedge pclk) disable iff (!presetn)
      run |=> p5_pu_on == ($past(p5_pu_r) & ~$past(p5_dir_r));
  endproperty
  a_p5_pu: assert property (p_p5_pu) // R16
    else $error("port5 pull-up does not follow control and direction");

  // a read-back setup two edges after the write sees the written byte
  property p_p5_pu_wr;
    @(posedge pclk) disable iff (!presetn)
      wr_en && hit_p5u ##2 setup && !pwrite && hit_p5u
        |=> prdata[7:0] == $past(pwdata[7:0], 3);
  endproperty
  a_p5_pu_wr: assert property (p_p5_pu_wr) // R17
    else $error("port5 pull-up control does not read back");

  property p_wr_next;
    @(posedge pclk) disable iff (!presetn)
      wr_en && hit_p4d |=> p4_data_r == $past(pwdata[7:0]) && !pready;
  endproperty
  a_wr_next: assert property (p_wr_next) // R18
    else $error("write did not land on the access edge");
endmodule

/* File: test/dbg_board.sv */
// dbg_board: board side of ports four and five, external drivers and pulls.
// assumes the bench sets the external levels and their enables.
`timescale 1ns/1ps
module dbg_board (
  input wire logic pclk,
  input wire logic [7:0] p4_out,
  input wire logic [7:0] p4_oe_n,
  input wire logic [7:0] p5_out,
  input wire logic [7:0] p5_oe_n,
  input wire logic [7:0] p5_pu_on,
  input wire logic [7:0] ext4,
  input wire logic [7:0] ext4_en,
  input wire logic [7:0] ext5,
  input wire logic [7:0] ext5_en,
  output logic [7:0] p4_in,
  output logic [7:0] p5_in
);
  logic [7:0] float_r = 8'h55;
  // an undriven pin wanders every cycle, so a read of it cannot pass
  always @(posedge pclk) begin
    float_r <= ~float_r;
  end
  // device drive wins, then the board driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p4_in[i] = !p4_oe_n[i] ? p4_out[i] : ext4_en[i] ? ext4[i] : float_r[i];
      p5_in[i] = !p5_oe_n[i] ? p5_out[i] : ext5_en[i] ? ext5[i] :
        p5_pu_on[i] ? 1'b1 : float_r[i];
    end
  end
endmodule

/* File: test/tb_top.sv */
// tb_top: register table walk, pin checks, power modes and reset.
// assumes the board model on the pins and an apb master driven here.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  typedef struct {logic wr; logic [15:0] idx; logic [7:0] d;
    logic [31:0] rd; logic er;} dbg_row_s;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  dbg_pkg::dbg_mode_e pwr_mode = dbg_pkg::PM_ACTIVE;
  logic [7:0] port3_direction = 8'h0F, port3_pu_on;
  logic [7:0] p4_in, p4_out, p4_oe_n, p5_in, p5_out, p5_oe_n, p5_pu_on;
  int failures = 0, cmp_count = 0;
  dbg_row_s rows [0:21];
  always #20 pclk = ~pclk;
  dbg_gpio i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwr_mode(pwr_mode), .port3_direction(port3_direction),
    .port3_pu_on(port3_pu_on), .p4_in(p4_in), .p4_out(p4_out),
    .p4_oe_n(p4_oe_n), .p5_in(p5_in), .p5_out(p5_out), .p5_oe_n(p5_oe_n),
    .p5_pu_on(p5_pu_on));
  dbg_board i_board (.pclk(pclk), .p4_out(p4_out), .p4_oe_n(p4_oe_n),
    .p5_out(p5_out), .p5_oe_n(p5_oe_n), .p5_pu_on(p5_pu_on),
    .ext4(8'hA5), .ext4_en(8'hFF), .ext5(8'h0C), .ext5_en(8'h0F),
    .p4_in(p4_in), .p5_in(p5_in));
  task automatic stop_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one apb transfer; the idle edge first keeps each signal to one driver
  task automatic apb(input logic w, input logic [15:0] idx,
      input logic [7:0] d, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pins follow registers one cycle late; sample off the edge
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  initial begin
    #100us;
    failures++;
    stop_test();
  end
  initial begin
    rows = '{
      '{1'b1, dbg_pkg::IDX_P4_DIR, 8'hFF, 32'h00000000, 1'b0},
      '{1'b0, dbg_pkg::IDX_P4_DATA, 8'h00, 32'h00000000, 1'b0},
      '{1'b1, dbg_pkg::IDX_P4_DIR, 8'h00, 32'h00000000, 1'b0},
      '{1'b1, dbg_pkg::IDX_P5_DIR, 8'hFF, 32'h00000000, 1'b0},
      '{1'b0, dbg_pkg::IDX_P5_DATA, 8'h00, 32'h00000000, 1'b0},
      '{1'b1, dbg_pkg::IDX_P5_DIR, 8'h00, 32'h00000000, 1'b0},
      '{1'b0, dbg_pkg::IDX_P4_DATA, 8'h00, 32'h000000A5, 1'b0},
      '{1'b0, dbg_pkg::IDX_P4_DIR, 8'h00, 32'h000000FF, 1'b0},
      '{1'b0, dbg_pkg::IDX_P5_DIR, 8'h00, 32'h000000FF, 1'b0},
      '{1'b0, dbg_pkg::IDX_P5_PU, 8'h00, 32'h00000000, 1'b0},
      '{1'b1, dbg_pkg::IDX_P4_DATA, 8'h3C, 32'h00000000, 1'b0},
      '{1'b1, dbg_pkg::IDX_P4_DIR, 8'hF0, 32'h00000000, 1'b0},
      '{1'b0, dbg_pkg::IDX_P4_DATA, 8'h00, 32'h00000035, 1'b0},
      '{1'b0, dbg_pkg::IDX_P4_DIR, 8'h00, 32'h000000FF, 1'b0},
      '{1'b1, dbg_pkg::IDX_P5_PU, 8'hF0, 32'h00000000, 1'b0},
      '{1'b0, dbg_pkg::IDX_P5_PU, 8'h00, 32'h000000F0, 1'b0},
      '{1'b0, dbg_pkg::IDX_P5_DATA, 8'h00, 32'h000000FC, 1'b0},
      '{1'b1, dbg_pkg::IDX_P5_DATA, 8'h5A, 32'h00000000, 1'b0},
      '{1'b1, dbg_pkg::IDX_P5_DIR, 8'hC0, 32'h00000000, 1'b0},
      '{1'b0, dbg_pkg::IDX_P5_DATA, 8'h00, 32'h0000007C, 1'b0},
      '{1'b1, dbg_pkg::IDX_P3_PU, 8'hFF, 32'h00000000, 1'b0},
      '{1'b0, 16'h0001, 8'h00, 32'h00000000, 1'b1}};
    // a real falling edge at time zero, so the flops reset before the
    // first clock edge and the reset checks never see unknowns
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // ordinary cases: reads compare data, every row compares the error flag
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].idx, rows[i].d, 4'hF);
      if (!rows[i].wr) `CHK(rd, rows[i].rd)
      `CHK(er, rows[i].er)
    end
    settle();
    `CHK(port3_pu_on, 8'hF0)
    `CHK(p4_out, 8'h3C)
    `CHK(p4_oe_n, 8'h0F)
    `CHK(p5_out, 8'h5A)
    `CHK(p5_oe_n, 8'h3F)
    `CHK(p5_pu_on, 8'h30)
    // a write without lane zero must leave the register alone
    apb(1'b1, dbg_pkg::IDX_P5_PU, 8'h00, 4'hE);
    apb(1'b0, dbg_pkg::IDX_P5_PU, 8'h00, 4'hF);
    `CHK(rd, 32'h000000F0)
    // sleep freezes the pins while the register still takes the write
    @(posedge pclk);
    pwr_mode <= dbg_pkg::PM_SLEEP;
    apb(1'b1, dbg_pkg::IDX_P4_DATA, 8'hC3, 4'hF);
    settle();
    `CHK(p4_out, 8'h3C)
    @(posedge pclk);
    pwr_mode <= dbg_pkg::PM_ACTIVE;
    settle();
    `CHK(p4_out, 8'hC3)
    // standby floats both ports
    @(posedge pclk);
    pwr_mode <= dbg_pkg::PM_STANDBY;
    settle();
    `CHK(p4_oe_n, 8'hFF)
    `CHK(p5_oe_n, 8'hFF)
    // subsleep keeps port5 as standby left it; subactive drives again
    @(posedge pclk);
    pwr_mode <= dbg_pkg::PM_SUBSLEEP;
    apb(1'b1, dbg_pkg::IDX_P5_DATA, 8'hA5, 4'hF);
    settle();
    `CHK(p5_out, 8'h5A)
    `CHK(p5_oe_n, 8'hFF)
    @(posedge pclk);
    pwr_mode <= dbg_pkg::PM_SUBACTIVE;
    settle();
    `CHK(p5_out, 8'hA5)
    `CHK(p5_oe_n, 8'h3F)
    // reset in mid-run acts at once, without a clock edge
    @(posedge pclk);
    pwr_mode <= dbg_pkg::PM_ACTIVE;
    presetn <= 1'b0;
    #5;
    `CHK(p4_oe_n, 8'hFF)
    `CHK(p5_oe_n, 8'hFF)
    `CHK(port3_pu_on, 8'h00)
    `CHK(p5_pu_on, 8'h00)
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    `CHK(p4_oe_n, 8'hFF)
    `CHK(p5_oe_n, 8'hFF)
    `CHK(port3_pu_on, 8'h00)
    apb(1'b0, dbg_pkg::IDX_P5_PU, 8'h00, 4'hF);
    `CHK(rd, 32'h00000000)
    apb(1'b0, dbg_pkg::IDX_P4_DATA, 8'h00, 4'hF);
    `CHK(rd, 32'h000000A5)
    stop_test();
  end
endmodule
